/* File: hw/osb_pkg.sv */
// Constants and types for oscillator selection and boot timing
`default_nettype none
package osb_pkg;
	// Clock mode codes
	localparam logic [7:0] CM_DIV2       = 8'h34;
	localparam logic [7:0] CM_DIV4       = 8'h14;
	localparam logic [7:0] CM_DIV8       = 8'h3C;
	localparam logic [7:0] CM_DIV16      = 8'h1C;
	localparam logic [7:0] CM_DIV32      = 8'h7C;
	localparam logic [7:0] CM_SLOW       = 8'hE4;
	localparam logic [7:0] CM_BOOT       = 8'hF4;
	// Enable bit positions
	localparam int         FAST_EN_BIT   = 4;
	localparam int         SLOW_EN_BIT   = 2;
	localparam int         XTAL_EN_BIT   = 7;
	// Source keys, built from mode bits [7:5] and [3]
	localparam logic [3:0] KEY_DIV2      = 4'h2;
	localparam logic [3:0] KEY_DIV4      = 4'h0;
	localparam logic [3:0] KEY_DIV8      = 4'h3;
	localparam logic [3:0] KEY_DIV16     = 4'h1;
	localparam logic [3:0] KEY_DIV32     = 4'h7;
	localparam logic [3:0] KEY_SLOW      = 4'hE;
	localparam logic [3:0] KEY_XTAL      = 4'hA;
	// Source edges (both polarities) per half period of the system clock
	localparam logic [5:0] EDGES_DIV2    = 6'h02;
	localparam logic [5:0] EDGES_DIV4    = 6'h04;
	localparam logic [5:0] EDGES_DIV8    = 6'h08;
	localparam logic [5:0] EDGES_DIV16   = 6'h10;
	localparam logic [5:0] EDGES_DIV32   = 6'h20;
	localparam logic [5:0] EDGES_UNDIV   = 6'h01;
	// Boot intervals in slow RC cycles
	localparam logic [11:0] FAST_BOOT_CYCLES   = 12'h02F;
	localparam logic [11:0] NORMAL_BOOT_CYCLES = 12'hB81;
	// Program addresses
	localparam logic [10:0] START_ADDR    = 11'h001;
	localparam logic [10:0] RESERVED_ADDR = 11'h000;
	// Reset values
	localparam logic [7:0] TRIM_RESET    = 8'h80;
	localparam logic [7:0] XTAL_RESET    = 8'h00;
	typedef enum logic [1:0] {SRC_SLOW = 2'h0, SRC_FAST = 2'h1, SRC_XTAL = 2'h2} osb_src_t;
	typedef enum logic [1:0] {BOOT_WAIT = 2'h0, BOOT_CAL = 2'h1, BOOT_RUN = 2'h3} osb_boot_t;
endpackage : osb_pkg
`default_nettype wire

/* File: hw/osb_clock_boot.sv */
// Oscillator enables, system clock selection and power-up boot sequencing
`default_nettype none
module osb_clock_boot (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Oscillator pins
	input  wire logic        fast_internal_rc,
	input  wire logic        slow_internal_rc,
	input  wire logic        crystal_oscillator,
	// Straps and calibration values
	input  wire logic        calibration_directive,
	input  wire logic        fast_boot_select,
	input  wire logic [7:0]  calibration_mode,
	input  wire logic [7:0]  calibration_trim,
	// Software write ports
	input  wire logic        clock_mode_we,
	input  wire logic [7:0]  clock_mode_wdata,
	input  wire logic        trim_we,
	input  wire logic [7:0]  trim_wdata,
	input  wire logic        crystal_ctrl_we,
	input  wire logic [7:0]  crystal_ctrl_wdata,
	// Register and status outputs
	output logic [7:0]       clock_mode,
	output logic [7:0]       fast_rc_trim,
	output logic [7:0]       crystal_ctrl,
	output logic             fast_rc_enable,
	output logic             slow_rc_enable,
	output logic             crystal_enable,
	output logic             system_clock,
	output logic             core_reset,
	output logic [10:0]      fetch_address,
	output logic             watchdog_enable,
	output logic             shared_port_pin_five_oe
);
	import osb_pkg::*;

	logic [4:0] sync1;
	logic [4:0] sync2;
	logic [4:0] sync3;
	logic [2:0] primed;
	osb_boot_t  boot_state;
	logic [11:0] boot_cnt;
	osb_src_t   cur_src;
	logic [5:0] cur_edges;
	logic [5:0] edge_cnt;
	logic       armed;
	logic       pend;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Two-stage synchronisers, an edge-history stage and its fill marker
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1  <= 5'h00;
			sync2  <= 5'h00;
			sync3  <= 5'h00;
			primed <= 3'h0;
		end else begin
			primed <= {primed[1:0], 1'b1};
			sync1 <= {fast_boot_select, calibration_directive, crystal_oscillator,
				slow_internal_rc, fast_internal_rc};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Edge detection and strap decode; edges count only once the history stage
	// holds a real pin sample, so a pin high at reset release is no false edge
	wire        hist_ok    = primed[2];
	wire        fast_edge  = hist_ok & (sync2[0] ^ sync3[0]);
	wire        slow_edge  = hist_ok & (sync2[1] ^ sync3[1]);
	wire        xtal_edge  = hist_ok & (sync2[2] ^ sync3[2]);
	wire        slow_rise  = hist_ok & sync2[1] & ~sync3[1];
	wire        cal_en     = sync2[3];
	wire        fast_boot  = sync2[4];
	wire [11:0] boot_target = fast_boot ? FAST_BOOT_CYCLES : NORMAL_BOOT_CYCLES;
	wire        boot_done  = slow_rise && (boot_cnt == boot_target - 12'h001);
	wire        running    = (boot_state == BOOT_RUN);

	// Accepted writes and next register values
	wire        cm_ok   = clock_mode_we & running;
	wire        trim_ok = trim_we & running;
	wire        xtal_ok = crystal_ctrl_we & running;
	wire        cal_now = (boot_state == BOOT_CAL) & cal_en;
	wire [7:0]  next_clock_mode = cm_ok ? clock_mode_wdata :
		cal_now ? calibration_mode : clock_mode;
	wire [7:0]  next_trim = trim_ok ? trim_wdata :
		cal_now ? calibration_trim : fast_rc_trim;
	wire [7:0]  next_xtal = xtal_ok ? crystal_ctrl_wdata : crystal_ctrl;

	// Source decode of the active clock mode
	wire [3:0]  key = {clock_mode[7:5], clock_mode[3]};
	wire        key_fast = (key == KEY_DIV2) || (key == KEY_DIV4) || (key == KEY_DIV8) ||
		(key == KEY_DIV16) || (key == KEY_DIV32);
	wire osb_src_t next_src = key_fast ? SRC_FAST : (key == KEY_XTAL) ? SRC_XTAL : SRC_SLOW;
	wire [5:0]  next_edges = (key == KEY_DIV2)  ? EDGES_DIV2 :
		(key == KEY_DIV4)  ? EDGES_DIV4 :
		(key == KEY_DIV8)  ? EDGES_DIV8 :
		(key == KEY_DIV16) ? EDGES_DIV16 :
		(key == KEY_DIV32) ? EDGES_DIV32 : EDGES_UNDIV;

	// Edge of the source now driving the system clock
	wire src_edge = (cur_src == SRC_FAST) ? fast_edge :
		(cur_src == SRC_XTAL) ? xtal_edge : slow_edge;
	wire toggle    = src_edge & armed & (edge_cnt == cur_edges - 6'h01);
	wire do_switch = toggle & system_clock & pend;

	// Boot sequencer: count slow RC cycles, apply calibration, release core
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			boot_state <= BOOT_WAIT;
			boot_cnt   <= 12'h000;
		end else begin
			case (boot_state)
				BOOT_WAIT: begin
					if (boot_done) begin
						boot_state <= BOOT_CAL;
					end else if (slow_rise) begin
						boot_cnt <= boot_cnt + 12'h001;
					end
				end
				BOOT_CAL: boot_state <= BOOT_RUN;
				BOOT_RUN: boot_state <= BOOT_RUN;
				default:  boot_state <= BOOT_WAIT;
			endcase
		end
	end

	// Core release, start address and post-boot status
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			core_reset              <= 1'b1;
			fetch_address           <= RESERVED_ADDR;
			watchdog_enable         <= 1'b0;
			shared_port_pin_five_oe <= 1'b0;
		end else if (boot_state == BOOT_CAL) begin
			core_reset              <= 1'b0;
			fetch_address           <= START_ADDR;
			watchdog_enable         <= ~cal_en;
			shared_port_pin_five_oe <= 1'b0;
		end
	end

	// Mode, trim and crystal control registers with their enables
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			clock_mode     <= CM_BOOT;
			fast_rc_trim   <= TRIM_RESET;
			crystal_ctrl   <= XTAL_RESET;
			fast_rc_enable <= CM_BOOT[FAST_EN_BIT];
			slow_rc_enable <= CM_BOOT[SLOW_EN_BIT];
			crystal_enable <= XTAL_RESET[XTAL_EN_BIT];
		end else begin
			clock_mode     <= next_clock_mode;
			fast_rc_trim   <= next_trim;
			crystal_ctrl   <= next_xtal;
			fast_rc_enable <= next_clock_mode[FAST_EN_BIT];
			slow_rc_enable <= next_clock_mode[SLOW_EN_BIT];
			crystal_enable <= next_xtal[XTAL_EN_BIT];
		end
	end

	// A new mode is taken at the end of a high phase; a new write wins over the take
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pend <= 1'b0;
		end else begin
			pend <= cm_ok | cal_now | (pend & ~do_switch);
		end
	end

	// Divider and switcher: the first edge after a switch only arms the count
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cur_src      <= SRC_SLOW;
			cur_edges    <= EDGES_UNDIV;
			edge_cnt     <= 6'h00;
			armed        <= 1'b0;
			system_clock <= 1'b0;
		end else if (do_switch) begin
			system_clock <= 1'b0;
			cur_src      <= next_src;
			cur_edges    <= next_edges;
			edge_cnt     <= 6'h00;
			armed        <= 1'b0;
		end else if (src_edge) begin
			armed    <= 1'b1;
			edge_cnt <= (toggle || !armed) ? 6'h00 : edge_cnt + 6'h01;
			if (toggle) begin
				system_clock <= ~system_clock;
			end
		end
	end

	// Checks on boot timing, decode and switching
	property p_boot_exit;
		(boot_state == BOOT_WAIT) && boot_done |=> (boot_state == BOOT_CAL);
	endproperty
	a_boot_exit: assert property (p_boot_exit) else $error("boot end missed");
	property p_boot_bound;
		(boot_state == BOOT_WAIT) |-> (boot_cnt < boot_target) && core_reset;
	endproperty
	a_boot_bound: assert property (p_boot_bound) else $error("boot overrun");
	property p_release;
		(boot_state == BOOT_CAL) |=> !core_reset && (fetch_address == START_ADDR);
	endproperty
	a_release: assert property (p_release) else $error("bad release");
	property p_both_rc;
		$fell(core_reset) && (clock_mode != CM_SLOW) |-> fast_rc_enable && slow_rc_enable;
	endproperty
	a_both_rc: assert property (p_both_rc) else $error("RC off after boot");
	property p_post_cal;
		$fell(core_reset) && cal_en |-> !watchdog_enable && !shared_port_pin_five_oe;
	endproperty
	a_post_cal: assert property (p_post_cal) else $error("bad post-boot status");
	property p_no_cal;
		(boot_state == BOOT_CAL) && !cal_en |=> $stable(clock_mode) && $stable(fast_rc_trim);
	endproperty
	a_no_cal: assert property (p_no_cal) else $error("defaults changed");
	property p_trim;
		trim_ok |=> (fast_rc_trim == $past(trim_wdata));
	endproperty
	a_trim: assert property (p_trim) else $error("trim not written");
	property p_xtal_indep;
		xtal_ok && !cm_ok |=> (crystal_enable == $past(crystal_ctrl_wdata[XTAL_EN_BIT]))
			&& $stable(fast_rc_enable) && $stable(slow_rc_enable);
	endproperty
	a_xtal_indep: assert property (p_xtal_indep) else $error("enables coupled");
	property p_mode_write;
		cm_ok |=> (clock_mode == $past(clock_mode_wdata)) && pend;
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode write lost");
	property p_div2;
		do_switch && (key == KEY_DIV2) |=> (cur_src == SRC_FAST) && (cur_edges == EDGES_DIV2);
	endproperty
	a_div2: assert property (p_div2) else $error("div2 decode");
	property p_div_mid;
		do_switch && (key == KEY_DIV8) |=> (cur_src == SRC_FAST) && (cur_edges == EDGES_DIV8);
	endproperty
	a_div_mid: assert property (p_div_mid) else $error("div8 decode");
	property p_slow;
		do_switch && (key == KEY_SLOW) |=> (cur_src == SRC_SLOW) && (cur_edges == EDGES_UNDIV);
	endproperty
	a_slow: assert property (p_slow) else $error("slow decode");
	property p_no_runt;
		$changed(system_clock) |-> $past(src_edge && armed);
	endproperty
	a_no_runt: assert property (p_no_runt) else $error("runt edge");
	property p_div4;
		do_switch && (key == KEY_DIV4) |=> (cur_src == SRC_FAST) && (cur_edges == EDGES_DIV4);
	endproperty
	a_div4: assert property (p_div4) else $error("div4 decode");
	property p_div16;
		do_switch && (key == KEY_DIV16) |=> (cur_src == SRC_FAST) && (cur_edges == EDGES_DIV16);
	endproperty
	a_div16: assert property (p_div16) else $error("div16 decode");
	property p_div32;
		do_switch && (key == KEY_DIV32) |=> (cur_src == SRC_FAST) && (cur_edges == EDGES_DIV32);
	endproperty
	a_div32: assert property (p_div32) else $error("div32 decode");
	property p_xtal_src;
		do_switch && (key == KEY_XTAL) |=> (cur_src == SRC_XTAL) && (cur_edges == EDGES_UNDIV);
	endproperty
	a_xtal_src: assert property (p_xtal_src) else $error("crystal decode");
	property p_switch_low;
		do_switch |=> !system_clock && !armed;
	endproperty
	a_switch_low: assert property (p_switch_low) else $error("switch not at low");
	property p_fetch_run;
		!core_reset |-> (fetch_address == START_ADDR);
	endproperty
	a_fetch_run: assert property (p_fetch_run) else $error("reserved fetch");
	property p_wait_frozen;
		(boot_state == BOOT_WAIT) |=> $stable(clock_mode) && $stable(fast_rc_trim);
	endproperty
	a_wait_frozen: assert property (p_wait_frozen) else $error("write during boot");
	property p_boot_count;
		(boot_state == BOOT_WAIT) && slow_rise && !boot_done |=>
			(boot_cnt == $past(boot_cnt) + 12'h001);
	endproperty
	a_boot_count: assert property (p_boot_count) else $error("boot count slip");
	// Cover points for the main scenarios
	c_boot:   cover property ($fell(core_reset));
	c_switch: cover property (do_switch && (key == KEY_DIV2));
	c_race:   cover property (do_switch && cm_ok);
	c_slow:   cover property (do_switch && (key == KEY_SLOW));
	c_xtal:   cover property (do_switch && (key == KEY_XTAL));
endmodule : osb_clock_boot
`default_nettype wire

/* File: testbench/osc_select_and_boot_timing_tb.sv */
// Self-checking bench for oscillator selection and boot timing
`default_nettype none
module osc_select_and_boot_timing_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import osb_pkg::*;
	// Design ports
	logic clk = 1'b0, reset = 1'b1;
	logic fast_internal_rc = 1'b0, slow_internal_rc = 1'b0, crystal_oscillator = 1'b0;
	logic calibration_directive = 1'b0, fast_boot_select = 1'b1;
	logic [7:0] calibration_mode = CM_DIV2, calibration_trim = 8'h5A;
	logic clock_mode_we = 1'b0, trim_we = 1'b0, crystal_ctrl_we = 1'b0;
	logic [7:0] clock_mode_wdata = 8'h00, trim_wdata = 8'h00, crystal_ctrl_wdata = 8'h00;
	logic [7:0] clock_mode, fast_rc_trim, crystal_ctrl;
	logic fast_rc_enable, slow_rc_enable, crystal_enable, system_clock, core_reset;
	logic [10:0] fetch_address;
	logic watchdog_enable, shared_port_pin_five_oe;
	int err_total = 0, checks_done = 0, cyc = 0, prev_hp = 4;
	// Mode table and half periods in clk cycles; no write stops the source it leaves
	logic [7:0] mtab [7] = '{CM_DIV4, CM_DIV8, CM_DIV16, CM_DIV32, 8'hB4, CM_SLOW, CM_DIV2};
	int htab [7] = '{8, 16, 32, 64, 10, 6, 4};

	osb_clock_boot DUT (.clk, .reset, .fast_internal_rc, .slow_internal_rc,
		.crystal_oscillator, .calibration_directive, .fast_boot_select, .calibration_mode,
		.calibration_trim, .clock_mode_we, .clock_mode_wdata, .trim_we, .trim_wdata,
		.crystal_ctrl_we, .crystal_ctrl_wdata, .clock_mode, .fast_rc_trim, .crystal_ctrl,
		.fast_rc_enable, .slow_rc_enable, .crystal_enable, .system_clock, .core_reset,
		.fetch_address, .watchdog_enable, .shared_port_pin_five_oe);

	// 250 MHz clock
	always #2 clk = ~clk;

	// Oscillator waveforms (edges every 2, 6, 10 clk), still while disabled, and run ceiling
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc % 2 == 1 && fast_rc_enable === 1'b1) fast_internal_rc <= ~fast_internal_rc;
		if (cyc % 6 == 5 && slow_rc_enable === 1'b1) slow_internal_rc <= ~slow_internal_rc;
		if (cyc % 10 == 9 && crystal_enable === 1'b1) crystal_oscillator <= ~crystal_oscillator;
		if (cyc == 60000) begin
			err_total++;
			test_done();
		end
	end

	task automatic chk(input string nm, input logic [10:0] ex, input logic [10:0] got);
		checks_done++;
		if (got !== ex) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	// One-cycle write pulse: 0 mode, 1 trim, 2 crystal control
	task automatic wr(input int sel, input logic [7:0] d);
		@(posedge clk);
		clock_mode_wdata <= d;
		trim_wdata <= d;
		crystal_ctrl_wdata <= d;
		clock_mode_we <= (sel == 0);
		trim_we <= (sel == 1);
		crystal_ctrl_we <= (sel == 2);
		@(posedge clk);
		clock_mode_we <= 1'b0;
		trim_we <= 1'b0;
		crystal_ctrl_we <= 1'b0;
		#1;
	endtask : wr

	task automatic boot(input logic cal, input logic fb, input int n);
		int t;
		@(posedge clk);
		calibration_directive <= cal;
		fast_boot_select <= fb;
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("mode_rst", CM_BOOT, clock_mode);
		chk("trim_rst", TRIM_RESET, fast_rc_trim);
		chk("xtal_rst", {XTAL_RESET, XTAL_RESET[XTAL_EN_BIT]},
			{crystal_ctrl, crystal_enable});
		chk("fetch_rst", RESERVED_ADDR, fetch_address);
		chk("hold_rst", 3'b111, {core_reset, fast_rc_enable, slow_rc_enable});
		@(posedge clk);
		reset <= 1'b0;
		wr(0, CM_DIV32);
		t = 0;
		while (core_reset !== 1'b0 && t < 40000) begin
			@(posedge clk);
			t++;
		end
		#1;
		chk("boot_len", 1, (t > n * 12 - 16) && (t < n * 12 + 16));
		chk("fetch", START_ADDR, fetch_address);
		chk("mode_boot", cal ? calibration_mode : CM_BOOT, clock_mode);
		chk("trim_boot", cal ? calibration_trim : TRIM_RESET, fast_rc_trim);
		chk("rc_on", 2'b11, {fast_rc_enable, slow_rc_enable});
		chk("wdog", !cal, watchdog_enable);
		chk("pin5_oe", 0, shared_port_pin_five_oe);
	endtask : boot

	// Full high and low phase of system_clock, sampled mid cycle
	task automatic phase(output int hi, output int lo);
		int g;
		hi = 0;
		lo = 0;
		g = 0;
		while (system_clock !== 1'b0 && g < 300) begin
			@(negedge clk);
			g++;
		end
		while (system_clock !== 1'b1 && g < 600) begin
			@(negedge clk);
			g++;
		end
		while (system_clock === 1'b1 && hi < 300) begin
			@(negedge clk);
			hi++;
		end
		while (system_clock === 1'b0 && lo < 300) begin
			@(negedge clk);
			lo++;
		end
	endtask : phase

	task automatic mode(input logic [7:0] m, input int hp);
		int hi, lo, mn;
		wr(0, m);
		chk("mode_reg", m, clock_mode);
		chk("rc_en", {m[FAST_EN_BIT], m[SLOW_EN_BIT]}, {fast_rc_enable, slow_rc_enable});
		mn = 1000;
		repeat (3) begin
			phase(hi, lo);
			mn = (hi < mn) ? hi : mn;
			mn = (lo < mn) ? lo : mn;
		end
		chk("no_runt", 1, mn >= ((hp < prev_hp) ? hp : prev_hp) - 1);
		chk("half_hi", 1, hi >= hp - 1 && hi <= hp + 1);
		chk("half_lo", 1, lo >= hp - 1 && lo <= hp + 1);
		prev_hp = hp;
	endtask : mode

	// Main sequence
	initial begin
		boot(1'b0, 1'b1, 47);
		boot(1'b1, 1'b0, 2945);
		wr(2, 8'h80);
		chk("xtal_on", 9'h101, {crystal_ctrl, crystal_enable});
		for (int i = 0; i < 7; i++) mode(mtab[i], htab[i]);
		wr(2, 8'h00);
		chk("xtal_off", 0, crystal_enable);
		wr(1, 8'h3C);
		chk("trim_wr", 8'h3C, fast_rc_trim);
		@(posedge clk);
		clock_mode_we <= 1'b1;
		clock_mode_wdata <= CM_DIV4;
		@(posedge clk);
		clock_mode_wdata <= CM_DIV16;
		@(posedge clk);
		clock_mode_we <= 1'b0;
		#1;
		chk("last_wins", CM_DIV16, clock_mode);
		test_done();
	end

	task automatic test_done();
		$display("checks_done=%0d err_total=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
endmodule : osc_select_and_boot_timing_tb
`default_nettype wire
